// [hw/efr_error_regs.sv]
// Purpose: Error flag (W1C) and error enable registers with their checks
// Assumes: Event strobes and register port come from same-clock logic
// Notes:   Flags update one cycle after their strobe; reads answer next cycle
//
// Functional notes
// [R1] An enabled read of a nonexistent address sets read-error bit 4.
// [R2] An enabled write to an invalid address sets write-error bit 3.
// [R3] An enabled checksum mismatch on a serial transaction sets bit 2.
// [R4] While bit 1 is enabled the register map is rechecked periodically.
// [R5] A map change with no host write since the reference sets bit 1.
// [R6] The power-up ROM check sets bit 0 on mismatch when enabled.
// [R7] Flags reset to 0; writing 1 clears a flag and writing 0 leaves it.
// [R8] A source sets its flag only while its enable bit is 1.
// [R9] Enable bit 12 runs a master-clock cycle counter, stopped while 0.
// [R10] Enable bit 11 gates the positive-input range fault and resets to 0.
// [R11] Invalid-address checks also need the chip-select-used bit set.
// [R12] A frame whose clock edge count is not a multiple of eight sets bit 5.
// [R13] Enable bits 15 to 13 read zero and ignore writes.
// [R14] A set event and a clear write in one cycle leave the flag set.
`timescale 1ns/1ns
module efr_error_regs #(
   parameter logic [efr_pkg::ADDR_W-1:0] ADDR_ERR_FLAGS =
      efr_pkg::ADDR_ERR_FLAGS_DEF,
   parameter int IMG_W = 128,
   parameter int MM_INTERVAL = efr_pkg::MM_INTERVAL_CYCLES,
   parameter int MCLK_CNT_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [efr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [efr_pkg::REG_W-1:0] reg_wdata,
   output logic [efr_pkg::REG_W-1:0] reg_rdata_ff,
   input wire logic chip_select_used,
   input wire logic rd_invalid_evt,
   input wire logic wr_invalid_evt,
   input wire logic spi_crc_evt,
   input wire logic sclk_edge_evt,
   input wire logic frame_end_evt,
   input wire logic rom_check_done,
   input wire logic rom_check_bad,
   input wire logic [efr_pkg::BIT_POS_INPUT:efr_pkg::BIT_EXT_LO] src_evt,
   input wire logic [IMG_W-1:0] regmap_image,
   input wire logic regmap_write_evt,
   output logic [efr_pkg::REG_W-1:0] error_flags_ff,
   output logic [efr_pkg::REG_W-1:0] error_enable_ff,
   output logic [MCLK_CNT_W-1:0] mclk_count_ff
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [efr_pkg::CRC_W-1:0] crc_of(
      input logic [IMG_W-1:0] img);
      logic [efr_pkg::CRC_W-1:0] c;
      logic fb;
      c = efr_pkg::CRC_INIT;
      for (int i = IMG_W - 1; i >= 0; i--) begin
         fb = c[efr_pkg::CRC_W-1] ^ img[i];
         c = {c[efr_pkg::CRC_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ efr_pkg::CRC_POLY;
         end
      end
      return c;
   endfunction : crc_of

   localparam int TICK_W = $clog2(MM_INTERVAL + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MM_INTERVAL - 1);
   localparam logic [TICK_W-1:0] TICK_ZERO = '0;
   localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
   localparam logic [MCLK_CNT_W-1:0] MCLK_ONE = MCLK_CNT_W'(1);

   logic wr_en_hit;
   logic wr_flag_hit;
   logic [efr_pkg::REG_W-1:0] set_vec;
   logic [efr_pkg::REG_W-1:0] nxt_error_flags;
   logic [efr_pkg::REG_W-1:0] nxt_error_enable;
   logic [efr_pkg::REG_W-1:0] nxt_reg_rdata;
   logic [MCLK_CNT_W-1:0] nxt_mclk_count;
   logic [efr_pkg::SCLK_CNT_W-1:0] sclk_cnt_ff;
   logic [efr_pkg::SCLK_CNT_W-1:0] nxt_sclk_cnt;
   logic [efr_pkg::SCLK_CNT_W-1:0] frame_total;
   logic [TICK_W-1:0] tick_cnt_ff;
   logic [TICK_W-1:0] nxt_tick_cnt;
   logic tick;
   efr_pkg::efr_mm_state_t mm_state_ff;
   efr_pkg::efr_mm_state_t nxt_mm_state;
   logic [efr_pkg::CRC_W-1:0] mm_ref_ff;
   logic [efr_pkg::CRC_W-1:0] nxt_mm_ref;
   logic [efr_pkg::CRC_W-1:0] crc_now;
   logic mm_bad;
   logic any_write;

   ////////////////////////////////////////////////////////////////////////
   // Register port decode and flag set/clear
   always_comb begin
      wr_en_hit = 1'b0;
      wr_flag_hit = 1'b0;
      if (reg_wr && reg_addr == efr_pkg::ADDR_ERR_EN) begin
         wr_en_hit = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_ERR_FLAGS) begin
         wr_flag_hit = 1'b1;
      end
   end

   assign frame_total = sclk_cnt_ff + (sclk_edge_evt ?
      efr_pkg::SCLK_CNT_ONE : efr_pkg::SCLK_CNT_ZERO);

   always_comb begin
      set_vec = '0;
      set_vec[efr_pkg::BIT_ROM_CRC] = rom_check_done && rom_check_bad; // [R6]
      set_vec[efr_pkg::BIT_MM_CRC] = mm_bad; // [R5]
      set_vec[efr_pkg::BIT_SPI_CRC] = spi_crc_evt; // [R3]
      set_vec[efr_pkg::BIT_WR_ERR] = wr_invalid_evt &&
         chip_select_used; // [R2] [R11]
      set_vec[efr_pkg::BIT_RD_ERR] = rd_invalid_evt &&
         chip_select_used; // [R1] [R11]
      set_vec[efr_pkg::BIT_SCLK_CNT] = frame_end_evt &&
         frame_total != efr_pkg::SCLK_CNT_ZERO; // [R12]
      set_vec[efr_pkg::BIT_POS_INPUT:efr_pkg::BIT_EXT_LO] = src_evt; // [R10]
      set_vec = set_vec & error_enable_ff & efr_pkg::ERR_FLAGS_MASK; // [R8]
   end

   always_comb begin
      nxt_error_flags = error_flags_ff;
      if (wr_flag_hit) begin
         nxt_error_flags = nxt_error_flags & ~reg_wdata; // [R7]
      end
      // Set applied after clear so a coincident event survives
      nxt_error_flags = nxt_error_flags | set_vec; // [R14]
      nxt_error_enable = error_enable_ff;
      if (wr_en_hit) begin
         nxt_error_enable = reg_wdata & efr_pkg::ERR_EN_WMASK; // [R13]
      end
      nxt_reg_rdata = reg_rdata_ff;
      if (reg_rd) begin
         if (reg_addr == efr_pkg::ADDR_ERR_EN) begin
            nxt_reg_rdata = error_enable_ff;
         end else if (reg_addr == ADDR_ERR_FLAGS) begin
            nxt_reg_rdata = error_flags_ff;
         end else begin
            nxt_reg_rdata = '0;
         end
      end
      nxt_mclk_count = mclk_count_ff;
      if (error_enable_ff[efr_pkg::BIT_MASTER_CLOCK_COUNTER_ON]) begin
         nxt_mclk_count = mclk_count_ff + MCLK_ONE; // [R9]
      end
      nxt_sclk_cnt = frame_end_evt ? efr_pkg::SCLK_CNT_ZERO : frame_total;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_flags_ff <= efr_pkg::ERR_FLAGS_RESET;
         error_enable_ff <= efr_pkg::ERR_EN_RESET;
         reg_rdata_ff <= '0;
         mclk_count_ff <= '0;
         sclk_cnt_ff <= efr_pkg::SCLK_CNT_ZERO;
      end else begin
         error_flags_ff <= nxt_error_flags;
         error_enable_ff <= nxt_error_enable;
         reg_rdata_ff <= nxt_reg_rdata;
         mclk_count_ff <= nxt_mclk_count;
         sclk_cnt_ff <= nxt_sclk_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Periodic register-map check; the CRC is one wide combinational tree,
   // traded for area against a serial engine since it runs once per tick
   assign crc_now = crc_of(regmap_image);
   assign any_write = regmap_write_evt || reg_wr;
   assign tick = tick_cnt_ff == TICK_LAST;
   assign mm_bad = tick && mm_state_ff == efr_pkg::EFR_MM_WATCH &&
      !any_write && crc_now != mm_ref_ff; // [R5]

   always_comb begin
      nxt_tick_cnt = tick ? TICK_ZERO : tick_cnt_ff + TICK_ONE; // [R4]
      nxt_mm_state = mm_state_ff;
      nxt_mm_ref = mm_ref_ff;
      case (mm_state_ff)
         efr_pkg::EFR_MM_IDLE: begin
            if (error_enable_ff[efr_pkg::BIT_MM_CRC]) begin
               nxt_mm_state = efr_pkg::EFR_MM_REF;
            end
         end
         efr_pkg::EFR_MM_REF: begin
            if (tick && !any_write) begin
               nxt_mm_ref = crc_now; // [R4]
               nxt_mm_state = efr_pkg::EFR_MM_WATCH;
            end
         end
         efr_pkg::EFR_MM_WATCH: begin
            // A write makes the reference stale; retake it next tick
            if (any_write) begin
               nxt_mm_state = efr_pkg::EFR_MM_REF;
            end else if (tick) begin
               nxt_mm_ref = crc_now; // [R4]
            end
         end
         default: begin
            nxt_mm_state = efr_pkg::EFR_MM_IDLE;
         end
      endcase
      if (!error_enable_ff[efr_pkg::BIT_MM_CRC]) begin
         nxt_mm_state = efr_pkg::EFR_MM_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_ff <= TICK_ZERO;
         mm_state_ff <= efr_pkg::EFR_MM_IDLE;
         mm_ref_ff <= efr_pkg::CRC_INIT;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         mm_state_ff <= nxt_mm_state;
         mm_ref_ff <= nxt_mm_ref;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_rd_err_set: assert property ( // [R1]
      rd_invalid_evt && chip_select_used &&
      error_enable_ff[efr_pkg::BIT_RD_ERR]
      |=> error_flags_ff[efr_pkg::BIT_RD_ERR])
      else $error("read error flag not set");
   a_csb_gate: assert property ( // [R11]
      !chip_select_used && !error_flags_ff[efr_pkg::BIT_WR_ERR] &&
      !(frame_end_evt || spi_crc_evt)
      |=> !error_flags_ff[efr_pkg::BIT_WR_ERR])
      else $error("write error set without chip select");
   a_crc_err_set: assert property ( // [R3]
      spi_crc_evt && error_enable_ff[efr_pkg::BIT_SPI_CRC]
      |=> error_flags_ff[efr_pkg::BIT_SPI_CRC])
      else $error("serial crc flag not set");
   a_flag_clear: assert property ( // [R7]
      wr_flag_hit && reg_wdata[efr_pkg::BIT_WR_ERR] &&
      !set_vec[efr_pkg::BIT_WR_ERR]
      |=> !error_flags_ff[efr_pkg::BIT_WR_ERR])
      else $error("write one did not clear flag");
   a_set_wins: assert property ( // [R14]
      wr_flag_hit && set_vec[efr_pkg::BIT_RD_ERR]
      |=> error_flags_ff[efr_pkg::BIT_RD_ERR])
      else $error("set lost against clear");
   a_disabled_hold: assert property ( // [R8]
      !error_enable_ff[efr_pkg::BIT_SPI_CRC] &&
      !error_flags_ff[efr_pkg::BIT_SPI_CRC]
      |=> !error_flags_ff[efr_pkg::BIT_SPI_CRC])
      else $error("disabled source set its flag");
   a_reserved_zero: assert property ( // [R13]
      error_enable_ff[efr_pkg::REG_W-1:efr_pkg::BIT_MASTER_CLOCK_COUNTER_ON+1] == '0)
      else $error("reserved enable bits not zero");
   a_mclk_count: assert property ( // [R9]
      error_enable_ff[efr_pkg::BIT_MASTER_CLOCK_COUNTER_ON] ##1
      error_enable_ff[efr_pkg::BIT_MASTER_CLOCK_COUNTER_ON]
      |-> mclk_count_ff == $past(mclk_count_ff) + MCLK_ONE)
      else $error("master clock counter not counting");
   a_mclk_hold: assert property ( // [R9]
      !$past(error_enable_ff[efr_pkg::BIT_MASTER_CLOCK_COUNTER_ON])
      |-> $stable(mclk_count_ff))
      else $error("master clock counter ran while off");
   a_edge_count: assert property ( // [R12]
      frame_end_evt && frame_total != efr_pkg::SCLK_CNT_ZERO &&
      error_enable_ff[efr_pkg::BIT_SCLK_CNT]
      |=> error_flags_ff[efr_pkg::BIT_SCLK_CNT] &&
      sclk_cnt_ff == efr_pkg::SCLK_CNT_ZERO)
      else $error("clock count error missed");
   a_rom_flag: assert property ( // [R6]
      rom_check_done && rom_check_bad && error_enable_ff[efr_pkg::BIT_ROM_CRC]
      |=> error_flags_ff[efr_pkg::BIT_ROM_CRC])
      else $error("rom crc flag not set");
   a_pos_gate: assert property ( // [R10]
      !error_enable_ff[efr_pkg::BIT_POS_INPUT] &&
      !error_flags_ff[efr_pkg::BIT_POS_INPUT]
      |=> !error_flags_ff[efr_pkg::BIT_POS_INPUT])
      else $error("positive input fault set while off");
   a_mm_flag: assert property ( // [R5]
      mm_bad && error_enable_ff[efr_pkg::BIT_MM_CRC]
      |=> error_flags_ff[efr_pkg::BIT_MM_CRC])
      else $error("register map crc flag not set");
   a_mm_tick: assert property ( // [R4]
      tick |=> tick_cnt_ff == TICK_ZERO ##1 tick_cnt_ff == TICK_ONE)
      else $error("check interval counter wrong");
   a_wr_err_set: assert property ( // [R2]
      wr_invalid_evt && chip_select_used &&
      error_enable_ff[efr_pkg::BIT_WR_ERR]
      |=> error_flags_ff[efr_pkg::BIT_WR_ERR])
      else $error("write error flag not set");
   a_rd_csb_gate: assert property ( // [R11]
      !chip_select_used && !error_flags_ff[efr_pkg::BIT_RD_ERR]
      |=> !error_flags_ff[efr_pkg::BIT_RD_ERR])
      else $error("read error set without chip select");
   a_zero_keeps: assert property ( // [R7]
      wr_flag_hit && !reg_wdata[efr_pkg::BIT_SPI_CRC] &&
      error_flags_ff[efr_pkg::BIT_SPI_CRC]
      |=> error_flags_ff[efr_pkg::BIT_SPI_CRC])
      else $error("writing zero cleared a flag");
   a_mm_quiet: assert property ( // [R5]
      !mm_bad && !error_flags_ff[efr_pkg::BIT_MM_CRC]
      |=> !error_flags_ff[efr_pkg::BIT_MM_CRC])
      else $error("register map flag set without mismatch");
   // Reserved bits must drop out of the stored value, not only on read
   a_en_write: assert property ( // [R13]
      wr_en_hit
      |=> error_enable_ff == ($past(reg_wdata) & efr_pkg::ERR_EN_WMASK))
      else $error("enable write not stored as masked");
endmodule : efr_error_regs

// [pkg/efr_pkg.sv]
// Purpose: Constants for the error flag and error enable register pair
// Assumes: 16-bit registers reached through the serial register port
// Notes:   Addresses are register indices on the serial port
package efr_pkg;
   localparam int REG_W = 16;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] ADDR_ERR_EN = 6'h07;
   localparam logic [ADDR_W-1:0] ADDR_ERR_FLAGS_DEF = 6'h06;
   localparam logic [REG_W-1:0] ERR_EN_RESET = 16'h0040;
   localparam logic [REG_W-1:0] ERR_FLAGS_RESET = 16'h0000;
   // Bits 15..13 of the enable register are reserved
   localparam logic [REG_W-1:0] ERR_EN_WMASK = 16'h1FFF;
   // Flags exist in bits 11..0; bits 15..12 read as zero
   localparam logic [REG_W-1:0] ERR_FLAGS_MASK = 16'h0FFF;
   localparam int BIT_ROM_CRC = 0;
   localparam int BIT_MM_CRC = 1;
   localparam int BIT_SPI_CRC = 2;
   localparam int BIT_WR_ERR = 3;
   localparam int BIT_RD_ERR = 4;
   localparam int BIT_SCLK_CNT = 5;
   localparam int BIT_EXT_LO = 6;
   localparam int BIT_POS_INPUT = 11;
   localparam int BIT_MASTER_CLOCK_COUNTER_ON = 12;
   localparam int SCLK_CNT_W = 3;
   localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_ZERO = 3'h0;
   localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_ONE = 3'h1;
   localparam int CRC_W = 8;
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
   localparam int MM_INTERVAL_CYCLES = 1024;
   typedef enum logic [1:0] {
      EFR_MM_IDLE = 2'b00,
      EFR_MM_REF = 2'b01,
      EFR_MM_WATCH = 2'b11
   } efr_mm_state_t;
endpackage : efr_pkg

// [verif/efr_error_regs_tb.sv]
// Purpose: Self-checking bench for the error flag and enable registers
// Assumes: Register-map check interval cut to 8 cycles
// Notes:   Host accesses go through the host model tasks
`timescale 1ns/1ns
module efr_error_regs_tb;
   localparam logic [5:0] FA = efr_pkg::ADDR_ERR_FLAGS_DEF;
   localparam logic [5:0] EA = efr_pkg::ADDR_ERR_EN;
   logic clk, rst, reg_wr, reg_rd, chip_select_used;
   logic rd_invalid_evt, wr_invalid_evt, spi_crc_evt;
   logic sclk_edge_evt, frame_end_evt, rom_check_done, rom_check_bad;
   logic regmap_write_evt;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_ff, error_flags_ff;
   logic [15:0] error_enable_ff, rv;
   logic [11:6] src_evt;
   logic [127:0] regmap_image;
   logic [31:0] mclk_count_ff, c0;
   int err_count = 0;
   int n_compared = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   efr_error_regs #(.MM_INTERVAL(8)) dut (.clk, .rst, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata_ff, .chip_select_used,
      .rd_invalid_evt, .wr_invalid_evt, .spi_crc_evt, .sclk_edge_evt,
      .frame_end_evt, .rom_check_done, .rom_check_bad, .src_evt,
      .regmap_image, .regmap_write_evt, .error_flags_ff,
      .error_enable_ff, .mclk_count_ff);
   efr_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata_ff);
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic complete_run;
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // One cycle of {read, write, checksum, positive input} strobes
   task automatic ev(input logic [3:0] e);
      @(posedge clk);
      #1 {rd_invalid_evt, wr_invalid_evt, spi_crc_evt, src_evt[11]} = e;
      @(posedge clk);
      #1 {rd_invalid_evt, wr_invalid_evt, spi_crc_evt, src_evt[11]} = 4'h0;
   endtask : ev
   // Clock edges on back-to-back cycles, then the frame end
   task automatic frame(input int n);
      @(posedge clk);
      #1 sclk_edge_evt = 1'b1;
      repeat (n) @(posedge clk);
      #1 sclk_edge_evt = 1'b0;
      frame_end_evt = 1'b1;
      @(posedge clk);
      #1 frame_end_evt = 1'b0;
   endtask : frame
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      chip_select_used = 1'b1;
      {rd_invalid_evt, wr_invalid_evt, spi_crc_evt, sclk_edge_evt} = 4'h0;
      {frame_end_evt, rom_check_done, rom_check_bad} = 3'h0;
      regmap_write_evt = 1'b0;
      src_evt = 6'h00;
      regmap_image = 128'h0;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk("enable", error_enable_ff, 32'h0040);
      chk("flags", error_flags_ff, 32'h0);
      chk("count", mclk_count_ff, 32'h0);
      ev(4'hF);
      chk("flags off", error_flags_ff, 32'h0);
      host.wr(EA, 16'hFFFF);
      host.rd(EA, rv);
      chk("enable rd", rv, 32'h1FFF);
      host.rd(6'h3F, rv);
      chk("unmapped", rv, 32'h0);
      c0 = mclk_count_ff;
      step(5);
      chk("count on", mclk_count_ff, c0 + 32'h5);
      chip_select_used = 1'b0;
      ev(4'hC);
      chk("no cs", error_flags_ff, 32'h0);
      chip_select_used = 1'b1;
      ev(4'hF);
      chk("set", error_flags_ff, 32'h081C);
      host.wr(FA, 16'h0010);
      host.wr(FA, 16'h0000);
      host.rd(FA, rv);
      chk("w1c", rv, 32'h080C);
      fork
         host.wr(FA, 16'h0004);
         ev(4'h2);
      join
      chk("set wins", error_flags_ff, 32'h080C);
      host.wr(FA, 16'hFFFF);
      chk("cleared", error_flags_ff, 32'h0);
      frame(8);
      chk("8 edges", error_flags_ff, 32'h0);
      frame(5);
      chk("5 edges", error_flags_ff, 32'h0020);
      rom_check_bad = 1'b1;
      rom_check_done = 1'b1;
      step(1);
      rom_check_done = 1'b0;
      chk("rom", error_flags_ff, 32'h0021);
      host.wr(FA, 16'hFFFF);
      // Counter stop and the map check share this enable write
      host.wr(EA, 16'h0002);
      c0 = mclk_count_ff;
      step(20);
      chk("count off", mclk_count_ff, c0);
      regmap_image = 128'h1;
      regmap_write_evt = 1'b1;
      step(1);
      regmap_write_evt = 1'b0;
      step(20);
      chk("mm write", error_flags_ff, 32'h0);
      regmap_image = 128'h3;
      for (int i = 0; i < 40 && error_flags_ff[1] !== 1'b1; i++) begin
         step(1);
      end
      chk("mm crc", error_flags_ff, 32'h0002);
      complete_run();
   end
endmodule : efr_error_regs_tb

// [verif/efr_host_model.sv]
// Purpose: Host side of the serial register port
// Assumes: One 16-bit word per access, one access at a time
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/1ns
module efr_host_model (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [efr_pkg::ADDR_W-1:0] reg_addr,
   output logic [efr_pkg::REG_W-1:0] reg_wdata,
   input wire logic [efr_pkg::REG_W-1:0] reg_rdata_ff
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
   end
   ////////////////////////////////////////
   // A 1 in a flag bit clears it, a 0 leaves it
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // Data is taken at the edge after the strobe, before it can move
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_ff;
   endtask : rd
endmodule : efr_host_model
